/* File: logic/cmd_interp.sv */
// Command interpreter: store/restore, home search and output commands
//
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module cmd_interp #(
  parameter logic [7:0] MODULE_ADDR = 8'h01,
  parameter logic [7:0] HOST_ADDR = 8'h02,
  parameter int NUM_VARS = 256,
  parameter int VAR_AW = 8
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic home_active,
  output logic home_start,
  output logic home_stop,
  output logic gp_output_a,
  output logic gp_output_b
);

  typedef enum logic [2:0] {
    ST_BOOT_RD = 3'h0,
    ST_BOOT_WR = 3'h1,
    ST_IDLE = 3'h2,
    ST_XFER_RD = 3'h3,
    ST_XFER_WR = 3'h4
  } state_t;

  state_t state_q;
  logic op_store_q;
  logic [VAR_AW-1:0] idx_q;
  logic [VAR_AW-1:0] uvar_sel_q;
  logic [31:0] accum_q;
  logic [31:0] global_q;
  logic [31:0] global_nv_q;
  logic home_meta_q;
  logic home_sync_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [3:0] byte_cnt_q;
  logic [63:0] frame_buf_q;
  logic [7:0] sum_q;
  cmd_pkg::frame_t frame_q;
  logic frame_pend_q;
  logic csum_ok_q;
  logic csum_err_q;
  cmd_pkg::reply_t reply_q;
  logic [7:0] reply_csum_q;
  logic reply_valid_q;
  logic reply_load;
  cmd_pkg::reply_t reply_d;
  logic [31:0] live_rdata;
  logic [31:0] nv_rdata;
  logic live_we;
  logic [VAR_AW-1:0] live_waddr;
  logic [31:0] live_wdata;
  logic [VAR_AW-1:0] live_raddr;
  logic nv_we;
  logic addr_phase;
  logic sw_write;
  logic take_frame;
  logic [7:0] reply_sum;
  logic [31:0] all_bits;
  logic [31:0] status_word;

  //////////////////////////////////////////////////////////////////////////
  // Bus slave: zero wait states, always OKAY

  assign addr_phase = hsel && hready && (htrans == cmd_pkg::HTRANS_NONSEQ);
  assign sw_write = wr_pend_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_q <= addr_phase && hwrite;
      wr_addr_q <= haddr[7:0];
    end
  end

  assign status_word = {16'h0000, reply_csum_q, 4'h0,
                        state_q inside {ST_BOOT_RD, ST_BOOT_WR},
                        home_sync_q, csum_err_q, reply_valid_q};

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h00000000;
    end
    else if (addr_phase && !hwrite)
    begin
      unique case (haddr[7:0])
        cmd_pkg::OFS_REPLY_HDR:
          hrdata <= {reply_q.host, reply_q.target, reply_q.status,
                     reply_q.instr};
        cmd_pkg::OFS_REPLY_VAL: hrdata <= reply_q.value;
        cmd_pkg::OFS_STATUS: hrdata <= status_word;
        cmd_pkg::OFS_ACCUM: hrdata <= accum_q;
        cmd_pkg::OFS_UVAR_SEL: hrdata <= 32'(uvar_sel_q);
        cmd_pkg::OFS_UVAR_DATA: hrdata <= live_rdata;
        cmd_pkg::OFS_GLOBAL_SET: hrdata <= global_q;
        cmd_pkg::OFS_GLOBAL_NV: hrdata <= global_nv_q;
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Software registers

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      accum_q <= cmd_pkg::ACCUM_RST;
      uvar_sel_q <= '0;
      global_q <= cmd_pkg::GLOBAL_RST;
      global_nv_q <= cmd_pkg::GLOBAL_RST;
    end
    else if (sw_write)
    begin
      if (wr_addr_q == cmd_pkg::OFS_ACCUM)
        accum_q <= hwdata;
      if (wr_addr_q == cmd_pkg::OFS_UVAR_SEL)
        uvar_sel_q <= hwdata[VAR_AW-1:0];
      if (wr_addr_q == cmd_pkg::OFS_GLOBAL_SET)
      begin
        global_q <= hwdata;
        global_nv_q <= hwdata;
      end
    end
  end

  // Search busy pin, two-stage sync
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      home_meta_q <= 1'b0;
      home_sync_q <= 1'b0;
    end
    else
    begin
      home_meta_q <= home_active;
      home_sync_q <= home_meta_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Frame assembly

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      byte_cnt_q <= 4'h0;
      frame_buf_q <= 64'h0;
      sum_q <= 8'h00;
      frame_q <= '0;
      csum_ok_q <= 1'b0;
    end
    else if (sw_write && wr_addr_q == cmd_pkg::OFS_FRAME_IN)
    begin
      if (byte_cnt_q == cmd_pkg::FRAME_LAST_BYTE[3:0])
      begin
        byte_cnt_q <= 4'h0;
        sum_q <= 8'h00;
        frame_q <= cmd_pkg::frame_t'(frame_buf_q);
        csum_ok_q <= (sum_q == hwdata[7:0]);
      end
      else
      begin
        byte_cnt_q <= byte_cnt_q + 4'h1;
        sum_q <= sum_q + hwdata[7:0];
        frame_buf_q <= {frame_buf_q[55:0], hwdata[7:0]};
      end
    end
  end

  assign take_frame = frame_pend_q && (state_q == ST_IDLE);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      frame_pend_q <= 1'b0;
    end
    else if (sw_write && wr_addr_q == cmd_pkg::OFS_FRAME_IN
             && byte_cnt_q == cmd_pkg::FRAME_LAST_BYTE[3:0])
    begin
      frame_pend_q <= 1'b1;
    end
    else if (take_frame)
    begin
      frame_pend_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // User variable storage: live copy and nonvolatile copy

  assign live_raddr = (state_q == ST_XFER_RD) ? idx_q : uvar_sel_q;
  assign live_we = (state_q == ST_BOOT_WR)
                   || (state_q == ST_XFER_WR && !op_store_q)
                   || (sw_write && wr_addr_q == cmd_pkg::OFS_UVAR_DATA);
  assign live_waddr = (state_q == ST_BOOT_WR || state_q == ST_XFER_WR)
                      ? idx_q : uvar_sel_q;
  assign live_wdata = (state_q == ST_BOOT_WR || state_q == ST_XFER_WR)
                      ? nv_rdata : hwdata;
  assign nv_we = (state_q == ST_XFER_WR) && op_store_q;

  uvar_mem #(.WIDTH(32), .DEPTH(NUM_VARS), .AW(VAR_AW)) u_live_mem (
    .clk(hclk),
    .rst_n(hresetn),
    .we(live_we),
    .waddr(live_waddr),
    .wdata(live_wdata),
    .raddr(live_raddr),
    .rdata_q(live_rdata)
  );

  uvar_mem #(.WIDTH(32), .DEPTH(NUM_VARS), .AW(VAR_AW)) u_nv_mem (
    .clk(hclk),
    .rst_n(hresetn),
    .we(nv_we),
    .waddr(idx_q),
    .wdata(live_rdata),
    .raddr(idx_q),
    .rdata_q(nv_rdata)
  );

  //////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= ST_BOOT_RD;
      idx_q <= '0;
      op_store_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        ST_BOOT_RD: state_q <= ST_BOOT_WR;
        ST_BOOT_WR:
        begin
          idx_q <= idx_q + 1'b1;
          state_q <= (idx_q == VAR_AW'(NUM_VARS - 1)) ? ST_IDLE : ST_BOOT_RD;
        end
        ST_IDLE:
        begin
          if (take_frame && csum_ok_q && frame_q.target == MODULE_ADDR
              && frame_q.bank == cmd_pkg::BANK_USER
              && (frame_q.instr == cmd_pkg::INSTR_STORE_UVAR
                  || frame_q.instr == cmd_pkg::INSTR_RESTORE_UVAR))
          begin
            idx_q <= frame_q.kind[VAR_AW-1:0];
            op_store_q <= (frame_q.instr == cmd_pkg::INSTR_STORE_UVAR);
            state_q <= ST_XFER_RD;
          end
        end
        ST_XFER_RD: state_q <= ST_XFER_WR;
        ST_XFER_WR: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Command decode and reply

  assign all_bits = (frame_q.value == cmd_pkg::VALUE_FROM_ACCUM)
                    ? accum_q : frame_q.value;

  always_comb
  begin
    reply_load = 1'b0;
    reply_d = '{host: HOST_ADDR, target: MODULE_ADDR,
                status: cmd_pkg::STAT_OK, instr: frame_q.instr,
                value: 32'h00000000};
    if (state_q == ST_XFER_WR)
    begin
      reply_load = 1'b1;
    end
    else if (take_frame && frame_q.target == MODULE_ADDR)
    begin
      reply_load = 1'b1;
      if (!csum_ok_q)
        reply_d.status = cmd_pkg::STAT_BAD_CSUM;
      else if (frame_q.instr == cmd_pkg::INSTR_STORE_UVAR
               || frame_q.instr == cmd_pkg::INSTR_RESTORE_UVAR)
      begin
        reply_load = (frame_q.bank != cmd_pkg::BANK_USER);
        reply_d.status = cmd_pkg::STAT_BAD_CMD;
      end
      else if (frame_q.instr == cmd_pkg::INSTR_HOME_SEARCH)
      begin
        if (frame_q.bank != cmd_pkg::MOTOR_ZERO)
          reply_d.status = cmd_pkg::STAT_BAD_CMD;
        else if (frame_q.kind == cmd_pkg::HOME_TYPE_STATUS)
          reply_d.value = {31'h0, home_sync_q};
        else if (frame_q.kind != cmd_pkg::HOME_TYPE_START
                 && frame_q.kind != cmd_pkg::HOME_TYPE_STOP)
          reply_d.status = cmd_pkg::STAT_BAD_TYPE;
      end
      else if (frame_q.instr == cmd_pkg::INSTR_SET_OUTPUT)
      begin
        if (frame_q.bank != cmd_pkg::BANK_USER)
          reply_d.status = cmd_pkg::STAT_BAD_CMD;
        else if (frame_q.kind == cmd_pkg::PORT_ALL)
        begin
          if (all_bits > cmd_pkg::VALUE_ALL_MAX)
            reply_d.status = cmd_pkg::STAT_BAD_VALUE;
        end
        else if (frame_q.kind > 8'h01)
          reply_d.status = cmd_pkg::STAT_BAD_TYPE;
        else if (frame_q.value > cmd_pkg::VALUE_ONE)
          reply_d.status = cmd_pkg::STAT_BAD_VALUE;
      end
      else
        reply_d.status = cmd_pkg::STAT_BAD_CMD;
    end
  end

  assign reply_sum = reply_d.host + reply_d.target + reply_d.status
                     + reply_d.instr + reply_d.value[31:24]
                     + reply_d.value[23:16] + reply_d.value[15:8]
                     + reply_d.value[7:0];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      reply_q <= '0;
      reply_csum_q <= 8'h00;
    end
    else if (reply_load)
    begin
      reply_q <= reply_d;
      reply_csum_q <= reply_sum;
    end
  end

  // Sticky flags: new event beats software clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      reply_valid_q <= 1'b0;
      csum_err_q <= 1'b0;
    end
    else
    begin
      if (reply_load)
        reply_valid_q <= 1'b1;
      else if (sw_write && wr_addr_q == cmd_pkg::OFS_STATUS
               && hwdata[cmd_pkg::ST_REPLY_VALID_BIT])
        reply_valid_q <= 1'b0;
      if (take_frame && !csum_ok_q)
        csum_err_q <= 1'b1;
      else if (sw_write && wr_addr_q == cmd_pkg::OFS_STATUS
               && hwdata[cmd_pkg::ST_CSUM_ERR_BIT])
        csum_err_q <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Search control pulses and outputs

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      home_start <= 1'b0;
      home_stop <= 1'b0;
      gp_output_a <= 1'b0;
      gp_output_b <= 1'b0;
    end
    else
    begin
      home_start <= 1'b0;
      home_stop <= 1'b0;
      if (reply_load && state_q == ST_IDLE
          && reply_d.status == cmd_pkg::STAT_OK)
      begin
        if (frame_q.instr == cmd_pkg::INSTR_HOME_SEARCH)
        begin
          home_start <= (frame_q.kind == cmd_pkg::HOME_TYPE_START);
          home_stop <= (frame_q.kind == cmd_pkg::HOME_TYPE_STOP);
        end
        if (frame_q.instr == cmd_pkg::INSTR_SET_OUTPUT)
        begin
          if (frame_q.kind == cmd_pkg::PORT_ALL)
          begin
            gp_output_a <= all_bits[0];
            gp_output_b <= all_bits[1];
          end
          else if (frame_q.kind[0])
            gp_output_b <= frame_q.value[0];
          else
            gp_output_a <= frame_q.value[0];
        end
      end
    end
  end

endmodule : cmd_interp

/* File: logic/cmd_pkg.sv */
// Shared constants and carrier types for the command interpreter
package cmd_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] OFS_FRAME_IN = 8'h00;
  localparam logic [7:0] OFS_REPLY_HDR = 8'h04;
  localparam logic [7:0] OFS_REPLY_VAL = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_ACCUM = 8'h10;
  localparam logic [7:0] OFS_UVAR_SEL = 8'h14;
  localparam logic [7:0] OFS_UVAR_DATA = 8'h18;
  localparam logic [7:0] OFS_GLOBAL_SET = 8'h1C;
  localparam logic [7:0] OFS_GLOBAL_NV = 8'h20;

  // Status register fields
  localparam int ST_REPLY_VALID_BIT = 0;
  localparam int ST_CSUM_ERR_BIT = 1;
  localparam int ST_HOME_ACTIVE_BIT = 2;
  localparam int ST_BOOT_BUSY_BIT = 3;
  localparam int ST_REPLY_CSUM_LSB = 8;

  // Protocol codes
  localparam logic [7:0] INSTR_STORE_UVAR = 8'h0B;
  localparam logic [7:0] INSTR_RESTORE_UVAR = 8'h0C;
  localparam logic [7:0] INSTR_HOME_SEARCH = 8'h0D;
  localparam logic [7:0] INSTR_SET_OUTPUT = 8'h0E;
  localparam logic [7:0] BANK_USER = 8'h02;
  localparam logic [7:0] MOTOR_ZERO = 8'h00;
  localparam logic [7:0] HOME_TYPE_START = 8'h00;
  localparam logic [7:0] HOME_TYPE_STOP = 8'h01;
  localparam logic [7:0] HOME_TYPE_STATUS = 8'h02;
  localparam logic [7:0] PORT_ALL = 8'hFF;
  localparam logic [31:0] VALUE_FROM_ACCUM = 32'hFFFFFFFF;
  localparam logic [31:0] VALUE_ALL_MAX = 32'h000000FF;
  localparam logic [31:0] VALUE_ONE = 32'h00000001;

  // Reply status codes
  localparam logic [7:0] STAT_OK = 8'h64;
  localparam logic [7:0] STAT_BAD_CSUM = 8'h01;
  localparam logic [7:0] STAT_BAD_CMD = 8'h02;
  localparam logic [7:0] STAT_BAD_TYPE = 8'h03;
  localparam logic [7:0] STAT_BAD_VALUE = 8'h04;

  // Reset values and counts
  localparam logic [7:0] FRAME_LAST_BYTE = 8'h08;
  localparam logic [31:0] GLOBAL_RST = 32'h00000000;
  localparam logic [31:0] ACCUM_RST = 32'h00000000;

  // AHB transfer type
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic [7:0] target;
    logic [7:0] instr;
    logic [7:0] kind;
    logic [7:0] bank;
    logic [31:0] value;
  } frame_t;

  typedef struct packed {
    logic [7:0] host;
    logic [7:0] target;
    logic [7:0] status;
    logic [7:0] instr;
    logic [31:0] value;
  } reply_t;

endpackage : cmd_pkg

/* File: logic/uvar_mem.sv */
// Word memory with one write port and a registered read port
`timescale 1ns/1ps
module uvar_mem #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata_q
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rdata_q <= '0;
    end
    else
    begin
      rdata_q <= mem[raddr];
    end
  end

endmodule : uvar_mem

/* File: tb/home_engine_model.sv */
// Search engine stand-in: busy from start until stop or run-out
`timescale 1ns/1ps
module home_engine_model #(
  parameter int RUN_LEN = 400
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic stop,
  output logic busy
);
  int left;
  // Stop wins over a start in the same cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      left <= 0;
    else if (stop)
      left <= 0;
    else if (start)
      left <= RUN_LEN;
    else if (left > 0)
      left <= left - 1;
  end
  assign busy = left > 0;
endmodule : home_engine_model

/* File: tb/cmd_interp_chk.sv */
// Port-level assertions for the command interpreter
`timescale 1ns/1ps
module cmd_interp_chk #(
  parameter int NUM_VARS = 256
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic home_active,
  input wire logic home_start,
  input wire logic home_stop,
  input wire logic gp_output_a,
  input wire logic gp_output_b
);
  // Boot walk may hold a finished frame back
  localparam int LIM = 2 * NUM_VARS + 16;
  logic req;
  logic [9:0] since_q;
  assign req = hsel && hready && htrans == cmd_pkg::HTRANS_NONSEQ;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////////
  // Cycles since the last frame byte write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      since_q <= 10'h3FF;
    else if (req && hwrite && haddr[7:0] == cmd_pkg::OFS_FRAME_IN)
      since_q <= 10'h000;
    else if (since_q != 10'h3FF)
      since_q <= since_q + 10'h001;
  end
  sequence s_rd_gap;
    req && !hwrite && haddr[7:0] > cmd_pkg::OFS_GLOBAL_NV ##1 hready;
  endsequence
  sequence s_pulse(sig);
    sig ##1 !sig;
  endsequence
  property p_ready_up;
    $past(hresetn) |-> hreadyout;
  endproperty
  property p_okay;
    hresp == 1'b0;
  endproperty
  property p_start_pulse;
    home_start |-> s_pulse(home_start);
  endproperty
  property p_stop_pulse;
    home_stop |-> s_pulse(home_stop);
  endproperty
  property p_excl;
    !(home_start && home_stop);
  endproperty
  property p_start_cause;
    home_start || home_stop |-> since_q <= LIM;
  endproperty
  property p_out_cause;
    $changed(gp_output_a) || $changed(gp_output_b) |-> since_q <= LIM;
  endproperty
  property p_unmapped;
    s_rd_gap |-> hrdata == 32'h0;
  endproperty
  a_ready_up: assert property (p_ready_up)
    else $error("bus not ready after reset");
  a_okay: assert property (p_okay)
    else $error("error response seen");
  a_start_pulse: assert property (p_start_pulse)
    else $error("start pulse too long");
  a_stop_pulse: assert property (p_stop_pulse)
    else $error("stop pulse too long");
  a_excl: assert property (p_excl)
    else $error("start and stop together");
  a_start_cause: assert property (p_start_cause)
    else $error("search control without a frame");
  a_out_cause: assert property (p_out_cause)
    else $error("output moved without a frame");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
endmodule : cmd_interp_chk

bind cmd_interp cmd_interp_chk #(.NUM_VARS(NUM_VARS)) chk_u (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .home_active(home_active), .home_start(home_start),
  .home_stop(home_stop), .gp_output_a(gp_output_a),
  .gp_output_b(gp_output_b));

/* File: tb/cmd_interp_tb_top.sv */
// Self-checking bench for the command interpreter
`timescale 1ns/1ps
module cmd_interp_tb_top;
  logic hclk, hresetn, hsel, hwrite, hready, hresp;
  logic [31:0] haddr, hwdata, hrdata, lf, acc, rd, v;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic busy, go, halt, out_a, out_b, ea, eb;
  logic [7:0] k, p;
  cmd_pkg::reply_t r;
  cmd_pkg::frame_t tbl [13];
  int failures, num_checks, starts, stops;
  cmd_interp #(.NUM_VARS(16), .VAR_AW(4)) dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hresp(hresp),
    .hrdata(hrdata), .home_active(busy), .home_start(go),
    .home_stop(halt), .gp_output_a(out_a), .gp_output_b(out_b));
  home_engine_model #(.RUN_LEN(400)) eng_u (.clk(hclk),
    .rst_n(hresetn), .start(go), .stop(halt), .busy(busy));
  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  always @(posedge hclk)
  begin
    starts += int'(go === 1'b1);
    stops += int'(halt === 1'b1);
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= cmd_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic do_reset();
    hresetn <= 1'b0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    {eb, ea} = 2'h0;
    acc = cmd_pkg::ACCUM_RST;
    rd = 32'hFFFFFFFF;
    for (int n = 0; n < 99 && rd[3] !== 1'b0; n++)
      bus(1'b0, 8'h0C, 32'h0);
    check({30'h0, out_b, out_a}, 32'h0);
  endtask : do_reset
  function automatic logic [7:0] exp_st(cmd_pkg::frame_t f);
    logic [31:0] x;
    x = (f.kind == 8'hFF && f.value == 32'hFFFFFFFF) ? acc : f.value;
    if (f.instr < 8'h0B || f.instr > 8'h0E)
      return cmd_pkg::STAT_BAD_CMD;
    if (f.instr == 8'h0D)
      return f.bank != 8'h00 ? cmd_pkg::STAT_BAD_CMD
        : f.kind > 8'h02 ? cmd_pkg::STAT_BAD_TYPE : cmd_pkg::STAT_OK;
    if (f.bank != 8'h02)
      return cmd_pkg::STAT_BAD_CMD;
    if (f.instr != 8'h0E)
      return cmd_pkg::STAT_OK;
    if (f.kind > 8'h01 && f.kind != 8'hFF)
      return cmd_pkg::STAT_BAD_TYPE;
    return x > (f.kind == 8'hFF ? 32'hFF : 32'h1)
      ? cmd_pkg::STAT_BAD_VALUE : cmd_pkg::STAT_OK;
  endfunction : exp_st
  task automatic cmd(input cmd_pkg::frame_t f, input logic [7:0] bad);
    logic [71:0] b;
    logic [7:0] s;
    logic [7:0] st;
    logic [31:0] sv;
    b = {f, 8'h00};
    s = 8'h00;
    for (int i = 0; i < 8; i++)
      s += b[71 - 8 * i -: 8];
    b[7:0] = s + bad;
    st = bad != 8'h00 ? cmd_pkg::STAT_BAD_CSUM : exp_st(f);
    for (int i = 0; i < 9; i++)
      bus(1'b1, 8'h00, {24'h0, b[71 - 8 * i -: 8]});
    rd = 32'h0;
    if (f.target == 8'h01)
      for (int n = 0; n < 40 && rd[0] !== 1'b1; n++)
        bus(1'b0, 8'h0C, 32'h0);
    else
      repeat (4) bus(1'b0, 8'h0C, 32'h0);
    sv = rd;
    check({31'h0, sv[0]}, {31'h0, f.target == 8'h01});
    check({31'h0, sv[1]}, {31'h0, bad != 8'h00});
    s = 8'h00;
    if (f.target == 8'h01)
    begin
      bus(1'b0, 8'h04, 32'h0);
      r[63:32] = rd;
      bus(1'b0, 8'h08, 32'h0);
      r.value = rd;
      for (int i = 0; i < 8; i++)
        s += r[63 - 8 * i -: 8];
      check(r[63:32], {8'h02, 8'h01, st, f.instr});
      check({24'h0, sv[15:8]}, {24'h0, s});
      bus(1'b1, 8'h0C, 32'h3);
    end
    v = (f.value == 32'hFFFFFFFF) ? acc : f.value;
    if (st == cmd_pkg::STAT_OK && f.instr == 8'h0E && f.target == 8'h01)
      case (f.kind)
        8'h00: ea = v[0];
        8'h01: eb = v[0];
        default: {eb, ea} = v[1:0];
      endcase
    check({30'h0, out_b, out_a}, {30'h0, eb, ea});
  endtask : cmd
  task automatic complete_run();
    if (failures == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////////
  // Run needs a few thousand cycles; limit at 50000
  initial
  begin
    #200000;
    failures++;
    complete_run();
  end
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    lf = 32'h4994;
    tbl = '{64'h010E000200000001, 64'h010E010200000001,
      64'h010EFF0200000000, 64'h010EFF02000000FF, 64'h010EFF0200000100,
      64'h010E000200000002, 64'h010E020200000001, 64'h010E000000000001,
      64'h010F000200000000, 64'h010D030000000000, 64'h010D000100000000,
      64'h030E000200000000, 64'h010B000100000000};
    do_reset();
    repeat (3)
    begin
      lf = lfsr(lf);
      bus(1'b1, 8'h1C, lf);
      @(posedge hclk);
      bus(1'b0, 8'h20, 32'h0);
      check(rd, lf);
    end
    bus(1'b1, 8'h40, lf);
    bus(1'b0, 8'h40, 32'h0);
    check(rd, 32'h0);
    foreach (tbl[i])
      cmd(tbl[i], 8'h00);
    cmd(tbl[0], 8'h01);
    // Accumulator as the bit source, within range
    acc = 32'h00000002;
    bus(1'b1, 8'h10, acc);
    cmd(64'h010EFF02FFFFFFFF, 8'h00);
    repeat (30)
    begin
      lf = lfsr(lf);
      if (lf[21])
      begin
        acc = {22'h0, lf[31:22]};
        bus(1'b1, 8'h10, acc);
      end
      p = lf[1:0] == 2'h2 ? 8'hFF : lf[1:0] == 2'h3 ? lf[9:2] : {7'h0, lf[0]};
      if (p == 8'hFF)
        v = lf[10] ? 32'hFFFFFFFF : {23'h0, lf[20:12]};
      else
        v = {30'h0, lf[12] & (p < 8'h02), lf[11]};
      cmd({8'h01, 8'h0E, p, 8'h02, v}, 8'h00);
    end
    repeat (2)
    begin
      lf = lfsr(lf);
      k = {4'h0, lf[3:0]};
      bus(1'b1, 8'h14, {24'h0, k});
      bus(1'b1, 8'h18, lf);
      cmd({8'h01, 8'h0B, k, 8'h02, ~lf}, 8'h00);
      bus(1'b1, 8'h18, ~lf);
      // Live read port lags a data write by one cycle
      @(posedge hclk);
      bus(1'b0, 8'h18, 32'h0);
      check(rd, ~lf);
      cmd({8'h01, 8'h0C, k, 8'h02, 32'h0}, 8'h00);
      bus(1'b0, 8'h18, 32'h0);
      check(rd, lf);
      bus(1'b1, 8'h18, ~lf);
      do_reset();
      bus(1'b1, 8'h14, {24'h0, k});
      repeat (2) @(posedge hclk);
      bus(1'b0, 8'h18, 32'h0);
      check(rd, lf);
    end
    cmd(64'h010D020000000000, 8'h00);
    check(r.value, 32'h0);
    cmd(64'h010D000000000000, 8'h00);
    cmd(64'h010D020000000000, 8'h00);
    check({31'h0, r.value != 32'h0}, 32'h1);
    cmd(64'h010D010000000000, 8'h00);
    cmd(64'h010D020000000000, 8'h00);
    check(r.value, 32'h0);
    check(starts * 16 + stops, 32'h11);
    complete_run();
  end
endmodule : cmd_interp_tb_top
